// >>> ppsc_pkg.sv
// Purpose: shared constants and types for the pixel port control block
// Assumes: one 250 MHz system clock, all pins asynchronous to it
// Notes: register offsets and field layouts are local choices
`default_nettype none
package ppsc_pkg;
  // system clock period in ns
  localparam int CLK_PERIOD_NS = 4;
  // register map index (4-bit register select)
  localparam logic [3:0] REG_GEN_CTRL = 4'h8;
  localparam logic [3:0] REG_IN_CLK = 4'h9;
  localparam logic [3:0] REG_OUT_CLK = 4'ha;
  localparam logic [3:0] REG_MUX_CTRL = 4'hb;
  localparam int REG_COUNT = 16;
  // reset values
  localparam logic [7:0] RST_REG_VAL = 8'h00;
  localparam logic RST_INDICATOR = 1'b1;
  // mux control value meaning pass-through mode
  localparam logic [7:0] MUX_PASSTHRU = 8'h2d;
  // general control fields
  localparam int GEN_HS_INV_BIT = 0;
  localparam int GEN_VS_INV_BIT = 1;
  localparam int GEN_IND_BIT = 7;
  // input clock select codes, low three bits of the input clock register
  localparam logic [2:0] CSEL_TTL0 = 3'h0;
  localparam logic [2:0] CSEL_TTL1 = 3'h1;
  localparam logic [2:0] CSEL_TTL2 = 3'h2;
  localparam logic [2:0] CSEL_ECL = 3'h3;
  localparam logic [2:0] CSEL_TTL_P = 3'h4;
  localparam logic [2:0] CSEL_TTL_N = 3'h5;
  // shift clock divider field in the output clock register
  localparam int SCLK_DIV_LSB = 0;
  localparam int SCLK_DIV_W = 4;

  typedef struct packed {
    logic [2:0] clk_ttl;
    logic ecl_p;
    logic ecl_n;
    logic hsync_n;
    logic vsync_n;
    logic blank_n;
    logic passthru_blank_n;
    logic [31:0] pixel;
    logic [7:0] passthru_pix;
  } ppsc_pins_s;

  typedef struct packed {
    logic [7:0] gen_ctrl;
    logic [7:0] in_clk;
    logic [7:0] out_clk;
    logic [7:0] mux_ctrl;
  } ppsc_regs_s;

  typedef struct packed {
    logic blank;
    logic green_sync;
    logic [7:0] mode;
    logic [31:0] pixel;
  } ppsc_video_s;
endpackage
`default_nettype wire

// >>> ppsc_host_port.sv
// Purpose: asynchronous 8-bit host register port with 16 registers
// Assumes: strobes and select are pins, synchronised here
// Notes: strobes must stay low for at least three system clocks
`timescale 1ns/100ps
`default_nettype none
module ppsc_host_port (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_reg_select,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output ppsc_pkg::ppsc_regs_s o_regs,
  output logic o_wr_stb,
  output logic [3:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  typedef enum logic {HP_IDLE, HP_READ} ppsc_hp_e;
  typedef logic [13:0] ppsc_hpin_t;

  ppsc_hpin_t s1_reg, s2_reg, s1_next, s2_next;
  logic rd_prev_reg, wr_prev_reg, rd_prev_next, wr_prev_next;
  logic [7:0] mem_reg [ppsc_pkg::REG_COUNT];
  logic [7:0] mem_next [ppsc_pkg::REG_COUNT];
  ppsc_hp_e st_reg, st_next;
  logic [7:0] data_next;
  logic oe_n_next, stb_next;
  logic [3:0] addr_next;
  logic [7:0] wdata_next;
  ppsc_pkg::ppsc_regs_s regs_next;
  logic rd_n_s, wr_n_s;
  logic [3:0] rs_s;
  logic [7:0] d_s;

  always_comb begin
    s1_next = {i_rd_n, i_wr_n, i_reg_select, i_data};
    s2_next = s1_reg;
    {rd_n_s, wr_n_s, rs_s, d_s} = s2_reg;
    rd_prev_next = rd_n_s;
    wr_prev_next = wr_n_s;
    mem_next = mem_reg;
    st_next = st_reg;
    data_next = o_data;
    oe_n_next = o_data_oe_n;
    stb_next = 1'b0;
    addr_next = o_wr_addr;
    wdata_next = o_wr_data;
    // data taken on the rising edge of the write strobe
    if (wr_n_s && !wr_prev_reg) begin
      mem_next[rs_s] = d_s;
      stb_next = 1'b1;
      addr_next = rs_s;
      wdata_next = d_s;
    end
    unique case (st_reg)
      HP_IDLE: begin
        // read launched on the falling edge of the read strobe
        if (!rd_n_s && rd_prev_reg) begin
          data_next = mem_reg[rs_s];
          oe_n_next = 1'b0;
          st_next = HP_READ;
        end
      end
      HP_READ: begin
        if (rd_n_s) begin
          oe_n_next = 1'b1;
          st_next = HP_IDLE;
        end
      end
    endcase
    regs_next.gen_ctrl = mem_next[ppsc_pkg::REG_GEN_CTRL];
    regs_next.in_clk = mem_next[ppsc_pkg::REG_IN_CLK];
    regs_next.out_clk = mem_next[ppsc_pkg::REG_OUT_CLK];
    regs_next.mux_ctrl = mem_next[ppsc_pkg::REG_MUX_CTRL];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      for (int i = 0; i < ppsc_pkg::REG_COUNT; i++) begin
        mem_reg[i] <= ppsc_pkg::RST_REG_VAL;
      end
      st_reg <= HP_IDLE;
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
      o_regs <= '0;
      o_wr_stb <= 1'b0;
      o_wr_addr <= 4'h0;
      o_wr_data <= 8'h00;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      rd_prev_reg <= rd_prev_next;
      wr_prev_reg <= wr_prev_next;
      mem_reg <= mem_next;
      st_reg <= st_next;
      o_data <= data_next;
      o_data_oe_n <= oe_n_next;
      o_regs <= regs_next;
      o_wr_stb <= stb_next;
      o_wr_addr <= addr_next;
      o_wr_data <= wdata_next;
    end
  end
endmodule
`default_nettype wire

// >>> ppsc_pixel_port.sv
// Purpose: pixel port front end: blanking, dot clock, shift clock, sync
// Assumes: dot clocks are pins sampled by the 250 MHz system clock
// Notes: dot clock edges are found by sampling, so dot rate < 125 MHz
`timescale 1ns/100ps
`default_nettype none
module ppsc_pixel_port (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_clk_ttl,
  input wire logic i_ecl_dot_clock_pair_p,
  input wire logic i_ecl_dot_clock_pair_n,
  input wire logic i_hsync_n,
  input wire logic i_vsync_n,
  input wire logic i_blank_n,
  input wire logic i_passthru_blank_in_n,
  input wire logic [31:0] i_pixel,
  input wire logic [7:0] i_passthru_pix,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_reg_select,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_sclk,
  output logic o_horiz_sync_out,
  output logic o_vert_sync_out,
  output logic o_green_current_out,
  output logic o_passthru_indicator_out,
  output ppsc_pkg::ppsc_video_s o_video
);
  function automatic logic is_passthru(input logic [7:0] mux);
    return mux == ppsc_pkg::MUX_PASSTHRU;
  endfunction

  ppsc_pkg::ppsc_pins_s p1_reg, p2_reg, p1_next, p2_next;
  ppsc_pkg::ppsc_regs_s regs;
  logic wr_stb;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] hp_data;
  logic hp_oe_n;

  logic dot_prev_reg, dot_prev_next;
  logic [ppsc_pkg::SCLK_DIV_W-1:0] div_cnt_reg, div_cnt_next;
  logic sclk_next, hs_next, vs_next, ind_next;
  ppsc_pkg::ppsc_video_s video_next;
  logic passthru, dot_level, dot_en;
  logic [2:0] csel;
  logic [ppsc_pkg::SCLK_DIV_W-1:0] div_val;

  ppsc_host_port u_host (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_rd_n(i_rd_n),
    .i_wr_n(i_wr_n),
    .i_reg_select(i_reg_select),
    .i_data(i_data),
    .o_data(hp_data),
    .o_data_oe_n(hp_oe_n),
    .o_regs(regs),
    .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data)
  );

  // every pin passes two flops before any logic reads it
  always_comb begin
    p1_next = {i_clk_ttl, i_ecl_dot_clock_pair_p, i_ecl_dot_clock_pair_n,
      i_hsync_n, i_vsync_n, i_blank_n, i_passthru_blank_in_n, i_pixel,
      i_passthru_pix};
    p2_next = p1_reg;
  end

  // dot source select and edge find on the synchronised level
  always_comb begin
    passthru = is_passthru(regs.mux_ctrl);
    csel = passthru ? ppsc_pkg::CSEL_TTL0 : regs.in_clk[2:0];
    unique case (csel)
      ppsc_pkg::CSEL_TTL0: dot_level = p2_reg.clk_ttl[0];
      ppsc_pkg::CSEL_TTL1: dot_level = p2_reg.clk_ttl[1];
      ppsc_pkg::CSEL_TTL2: dot_level = p2_reg.clk_ttl[2];
      ppsc_pkg::CSEL_ECL: dot_level = p2_reg.ecl_p & ~p2_reg.ecl_n;
      ppsc_pkg::CSEL_TTL_P: dot_level = p2_reg.ecl_p;
      ppsc_pkg::CSEL_TTL_N: dot_level = p2_reg.ecl_n;
      // spare codes fall back to the first TTL input
      default: dot_level = p2_reg.clk_ttl[0];
    endcase
    dot_prev_next = dot_level;
    dot_en = dot_level & ~dot_prev_reg;
  end

  // pixels, blanking and sync move together on one dot edge
  always_comb begin
    video_next = o_video;
    hs_next = o_horiz_sync_out;
    vs_next = o_vert_sync_out;
    if (dot_en) begin
      video_next.blank = passthru ? ~p2_reg.passthru_blank_n
                                  : ~p2_reg.blank_n;
      video_next.mode = regs.mux_ctrl;
      video_next.pixel = passthru ? {24'h000000, p2_reg.passthru_pix}
                                  : p2_reg.pixel;
      video_next.green_sync = ~passthru &
        (~p2_reg.hsync_n | ~p2_reg.vsync_n);
      if (passthru) begin
        hs_next = p2_reg.hsync_n;
        vs_next = p2_reg.vsync_n;
      end else begin
        hs_next = p2_reg.hsync_n ^ regs.gen_ctrl[ppsc_pkg::GEN_HS_INV_BIT];
        vs_next = p2_reg.vsync_n ^ regs.gen_ctrl[ppsc_pkg::GEN_VS_INV_BIT];
      end
    end
  end

  always_comb begin
    // shift clock half period is div_val + 1 dot clocks
    div_val = regs.out_clk[ppsc_pkg::SCLK_DIV_LSB +: ppsc_pkg::SCLK_DIV_W];
    div_cnt_next = div_cnt_reg;
    sclk_next = o_sclk;
    // clearing on the capture edge too keeps the toggle off that edge
    if (o_video.blank || (dot_en && video_next.blank)) begin
      div_cnt_next = '0;
      sclk_next = 1'b0;
    end else if (dot_en) begin
      if (div_cnt_reg == div_val) begin
        div_cnt_next = '0;
        sclk_next = ~o_sclk;
      end else begin
        div_cnt_next = div_cnt_reg + 1'b1;
      end
    end
  end

  always_comb begin
    // indicator drives only the pin; nothing internal reads it
    ind_next = o_passthru_indicator_out;
    if (wr_stb && wr_addr == ppsc_pkg::REG_MUX_CTRL) begin
      ind_next = !is_passthru(wr_data);
    end else if (wr_stb && wr_addr == ppsc_pkg::REG_GEN_CTRL &&
                 wr_data[ppsc_pkg::GEN_IND_BIT] && passthru) begin
      ind_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      p1_reg <= '1;
      p2_reg <= '1;
    end else begin
      p1_reg <= p1_next;
      p2_reg <= p2_next;
    end
  end

  // preset matches the synchroniser preset: no false dot edge after reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dot_prev_reg <= 1'b1;
    end else begin
      dot_prev_reg <= dot_prev_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_horiz_sync_out <= 1'b1;
      o_vert_sync_out <= 1'b1;
      o_green_current_out <= 1'b0;
      o_video <= '0;
    end else begin
      o_horiz_sync_out <= hs_next;
      o_vert_sync_out <= vs_next;
      o_green_current_out <= video_next.green_sync;
      o_video <= video_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_reg <= '0;
      o_sclk <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      o_sclk <= sclk_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_passthru_indicator_out <= ppsc_pkg::RST_INDICATOR;
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      o_passthru_indicator_out <= ind_next;
      // one more stage keeps every top output on a local flop
      o_data <= hp_data;
      o_data_oe_n <= hp_oe_n;
    end
  end
endmodule
`default_nettype wire

// >>> ppsc_pixel_port_assertions.sv
// Purpose: concurrent checks on pixel port outputs
// Assumes: host strobes held low at least 8 clocks
// Notes: bound to ppsc_pixel_port
`timescale 1ns/100ps
`default_nettype none
module ppsc_pixel_port_assertions (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic o_data_oe_n,
  input wire logic o_sclk,
  input wire logic o_green_current_out,
  input wire logic o_passthru_indicator_out,
  input wire ppsc_pkg::ppsc_video_s o_video
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_sclk_blank_low:
    assert property (o_video.blank ##1 o_video.blank |-> !o_sclk)
      else $error("shift clock high in blanking");
  a_sclk_edge_space:
    assert property ($changed(o_sclk) |=> $stable(o_sclk) [*3])
      else $error("shift clock faster than dot clock");
  a_pt_no_green:
    assert property (o_video.mode == ppsc_pkg::MUX_PASSTHRU
      |-> !o_video.green_sync && !o_green_current_out)
      else $error("green sync in pass-through");
  a_pt_pixel_narrow:
    assert property (o_video.mode == ppsc_pkg::MUX_PASSTHRU
      |-> o_video.pixel[31:8] == 24'h0)
      else $error("wide pixel in pass-through");
  a_rd_drive_start:
    assert property ($fell(o_data_oe_n) |-> !$past(i_rd_n, 2))
      else $error("bus driven without read");
  a_rd_drive_end:
    assert property ($rose(o_data_oe_n) |-> $past(i_rd_n, 2))
      else $error("bus released during read");
  a_bus_idle_off:
    assert property (i_rd_n [*8] |-> o_data_oe_n)
      else $error("bus driven while idle");
  a_ind_write_only:
    assert property ($changed(o_passthru_indicator_out)
      |-> !$past(i_wr_n, 6))
      else $error("indicator moved without write");
endmodule
bind ppsc_pixel_port ppsc_pixel_port_assertions u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd_n(i_rd_n),
  .i_wr_n(i_wr_n), .o_data_oe_n(o_data_oe_n), .o_sclk(o_sclk),
  .o_green_current_out(o_green_current_out),
  .o_passthru_indicator_out(o_passthru_indicator_out),
  .o_video(o_video));
`default_nettype wire

// >>> ppsc_host_model.sv
// Purpose: host processor on the async register port
// Assumes: called from the bench off the falling clock edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module ppsc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_oe_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [3:0] o_sel,
  output logic [7:0] o_bus
);
  logic drv;
  logic [7:0] hd;
  initial begin
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_sel = 4'h0;
    hd = 8'h5a;
    drv = 1'b0;
  end
  // no pull on the bus, so never leave it at the last value
  assign o_bus = !i_dev_oe_n ? i_dev_data : drv ? hd : ~hd;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_sel = a;
    hd = d;
    drv = 1'b1;
    repeat (4) @(negedge i_clk);
    o_wr_n = 1'b0;
    repeat (8) @(negedge i_clk);
    o_wr_n = 1'b1;
    repeat (4) @(negedge i_clk);
    drv = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_sel = a;
    repeat (4) @(negedge i_clk);
    o_rd_n = 1'b0;
    repeat (8) @(negedge i_clk);
    d = o_bus;
    o_rd_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for the pixel port block
// Assumes: one dot clock source (a pin, or both pins of the ECL pair) toggles at a time, picked by src
// Notes: random stimulus, seed fixed
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, rst, dot, hs_n, vs_n, bl_n, pbl_n;
  logic oe_n, sclk, hso, vso, grn, ind, rd_n, wr_n;
  logic [31:0] pix;
  logic [7:0] ptp, rdv, ev, d_o, bus;
  logic [3:0] sel;
  logic [2:0] src;
  ppsc_pkg::ppsc_video_s vid;
  int mismatches, tests_run, n, t0;
  ppsc_host_model host (.i_clk(clk), .i_dev_data(d_o),
    .i_dev_oe_n(oe_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel(sel),
    .o_bus(bus));
  ppsc_pixel_port dut (.i_clk(clk), .i_sys_rst(rst),
    .i_clk_ttl({3{dot}} & (3'h1 << src)),
    .i_ecl_dot_clock_pair_p(dot & (src == 3'h3 || src == 3'h4)),
    .i_ecl_dot_clock_pair_n(src == 3'h3 ? ~dot : dot & (src == 3'h5)),
    .i_hsync_n(hs_n), .i_vsync_n(vs_n), .i_blank_n(bl_n),
    .i_passthru_blank_in_n(pbl_n), .i_pixel(pix), .i_passthru_pix(ptp),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_reg_select(sel), .i_data(bus),
    .o_data(d_o), .o_data_oe_n(oe_n), .o_sclk(sclk),
    .o_horiz_sync_out(hso), .o_vert_sync_out(vso),
    .o_green_current_out(grn), .o_passthru_indicator_out(ind),
    .o_video(vid));
  function automatic logic egrn(logic h, logic v);
    return !h || !v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rnd;
    @(negedge clk);
    {pix, ptp, hs_n, vs_n, bl_n, pbl_n} = 44'({$urandom, $urandom});
    repeat (24) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // odd offset keeps dot edges off the system clock edges
  initial begin
    dot = 1'b0;
    #3;
    forever #16 dot = ~dot;
  end
  initial begin
    #100000;
    mismatches++;
    results;
  end
  initial begin
    {rst, hs_n, vs_n, bl_n, pbl_n, src, pix, ptp} = {5'h1f, 3'h0, 40'h0};
    mismatches = 0;
    tests_run = 0;
    n = $urandom(95);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 16; a++) begin
      host.rd(a[3:0], rdv);
      chk("reset reg", rdv, 8'h00);
      ev = 8'($urandom);
      host.wr(a[3:0], ev);
      host.rd(a[3:0], rdv);
      chk("reg rw", rdv, ev);
    end
    $display("registers done");
    host.wr(ppsc_pkg::REG_MUX_CTRL, 8'h00);
    chk("ind normal", ind, 1'b1);
    host.wr(ppsc_pkg::REG_MUX_CTRL, ppsc_pkg::MUX_PASSTHRU);
    chk("ind pt", ind, 1'b0);
    host.wr(ppsc_pkg::REG_GEN_CTRL, 8'h80);
    chk("ind bit7", ind, 1'b1);
    $display("indicator done");
    // indicator is high here, so pass-through must not care about it
    host.wr(ppsc_pkg::REG_IN_CLK, 8'h01);
    host.wr(ppsc_pkg::REG_GEN_CTRL, 8'h83);
    repeat (4) begin
      rnd;
      chk("pt pixel", vid.pixel, {24'h0, ptp});
      chk("pt blank", vid.blank, !pbl_n);
      chk("pt hsync", hso, hs_n);
      chk("pt vsync", vso, vs_n);
      chk("pt mode", vid.mode, 8'h2d);
      chk("pt green", grn, 1'b0);
    end
    $display("pass-through done");
    host.wr(ppsc_pkg::REG_MUX_CTRL, 8'h00);
    for (int c = 0; c < 6; c++) begin
      src = 3'h7;
      host.wr(ppsc_pkg::REG_IN_CLK, 8'(c));
      host.wr(ppsc_pkg::REG_GEN_CTRL, 8'(c % 4));
      src = c[2:0];
      rnd;
      chk("pixel", vid.pixel, pix);
      chk("blank", vid.blank, !bl_n);
      chk("hsync", hso, hs_n ^ c[0]);
      chk("vsync", vso, vs_n ^ c[1]);
      chk("green", grn, egrn(hs_n, vs_n));
      chk("green flag", vid.green_sync, egrn(hs_n, vs_n));
      chk("mode", vid.mode, 8'h00);
      n = pix;
      src = 3'((c + 2) % 6);
      rnd;
      chk("pixel held", vid.pixel, n);
    end
    $display("clock select done");
    host.wr(ppsc_pkg::REG_IN_CLK, 8'h00);
    src = 3'h0;
    bl_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ev = 8'($urandom_range(3));
      host.wr(ppsc_pkg::REG_OUT_CLK, ev);
      @(posedge sclk);
      t0 = int'($time);
      @(posedge sclk);
      chk("sclk period", 32'((int'($time) - t0) / 4), 16 * (ev + 1));
    end
    @(negedge clk);
    bl_n = 1'b0;
    repeat (24) @(negedge clk);
    n = 0;
    repeat (64) begin
      @(negedge clk);
      n = n | sclk;
    end
    chk("sclk blanked", n, 0);
    $display("shift clock done");
    results;
  end
endmodule
`default_nettype wire
